// File: rtl/tsr_cfg.svh
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
/*
  Addresses, field positions, reset values and codes of the report words.
  Assumes word addressing; each address names one 16-bit word.
*/
// Word addresses
`define TSR_ADDR_PRODUCT 8'h00
`define TSR_ADDR_APP_MAJOR 8'h01
`define TSR_ADDR_APP_MINOR 8'h02
`define TSR_ADDR_APP_PATCH_LO 8'h03
`define TSR_ADDR_APP_PATCH_HI 8'h04
`define TSR_ADDR_LIBRARY 8'h05
`define TSR_ADDR_LIB_MAJOR 8'h06
`define TSR_ADDR_LIB_MINOR 8'h07
`define TSR_ADDR_LIB_PATCH_LO 8'h08
`define TSR_ADDR_LIB_PATCH_HI 8'h09
`define TSR_ADDR_GESTURE 8'h0E
`define TSR_ADDR_INFO 8'h0F
`define TSR_ADDR_SYSCTL 8'h33
// Gesture word fields
`define TSR_GES_SWHOLD_LO 12
`define TSR_GES_SWIPE_LO 8
`define TSR_GES_RSVD_LO 5
`define TSR_GES_PALM 4
`define TSR_GES_HOLD 3
`define TSR_GES_TRIPLE 2
`define TSR_GES_DOUBLE 1
`define TSR_GES_SINGLE 0
// Information word fields and system control acknowledge bit
`define TSR_INFO_LP_DET 14
`define TSR_INFO_TOO_MANY 12
`define TSR_INFO_MOTION 10
`define TSR_INFO_COUNT_LO 8
`define TSR_INFO_SHOW_RST 7
`define TSR_INFO_ALT_RETUNE 6
`define TSR_INFO_ALT_ERR 5
`define TSR_INFO_PAD_RETUNE 4
`define TSR_INFO_PAD_ERR 3
`define TSR_INFO_MODE_LO 0
`define TSR_SYSCTL_ACK 7
// Reset values
`define TSR_WORD_RST 16'h0000
`define TSR_TUNE_RST 4'h0
// Codes
`define TSR_MODE_ACTIVE 3'h0
`define TSR_MODE_IDLE_TOUCH 3'h1
`define TSR_MODE_IDLE 3'h2
`define TSR_MODE_LP_ONE 3'h3
`define TSR_MODE_LP_TWO 3'h4
`define TSR_COUNT_MAX 2'h2
`define TSR_EVT_LAT 2
`endif

// File: rtl/tsr_pkg.sv
/*
  Types shared by the report word modules.
  Assumes tsr_cfg.svh is on the include path.
*/
`include "tsr_cfg.svh"
package tsr_pkg;
  typedef logic [15:0] tsr_word_type;
  typedef logic [7:0] tsr_addr_type;
  typedef enum logic [2:0] {
    tsr_mode_active = `TSR_MODE_ACTIVE,
    tsr_mode_idle_touch = `TSR_MODE_IDLE_TOUCH,
    tsr_mode_idle = `TSR_MODE_IDLE,
    tsr_mode_low_power_one = `TSR_MODE_LP_ONE,
    tsr_mode_low_power_two = `TSR_MODE_LP_TWO
  } tsr_power_mode_type;
endpackage

// File: rtl/tsr_rep_if.sv
/*
  Report bundle between the top and its capture modules.
  Assumes all parties run on core_clk.
*/
`timescale 1ns/1ps
interface tsr_rep_if;
  logic report_stb;
  tsr_pkg::tsr_word_type gesture_raw;
  tsr_pkg::tsr_word_type gesture_word;
  logic gesture_seen;
  logic [3:0] tune_raw;
  logic [3:0] tune_bits;
  modport src (
    output report_stb, gesture_raw, tune_raw,
    input gesture_word, gesture_seen, tune_bits
  );
  modport ges (
    input report_stb, gesture_raw,
    output gesture_word, gesture_seen
  );
  modport tune (
    input report_stb, tune_raw,
    output tune_bits
  );
endinterface

// File: rtl/tsr_gesture.sv
/*
  Gesture word capture.
  Assumes report_stb is a one-cycle pulse from the sensing engine.
*/
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_gesture (
  input wire logic core_clk,
  input wire logic rst_n,
  tsr_rep_if.ges rep
);
  localparam tsr_pkg::tsr_word_type RSVD_MASK = 16'h00E0;
  tsr_pkg::tsr_word_type word_q;
  logic seen_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= `TSR_WORD_RST;
    end else if (rep.report_stb) begin
      word_q <= rep.gesture_raw & ~RSVD_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= rep.report_stb && ((rep.gesture_raw & ~RSVD_MASK) != 16'h0000);
    end
  end

  assign rep.gesture_word = word_q;
  assign rep.gesture_seen = seen_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  gesture_rsvd_zero_a:
    assert property (rep.gesture_word[7:5] == 3'h0)
    else $error("gesture reserved bits set");
  gesture_latch_a:
    assert property (rep.report_stb |=>
      rep.gesture_word[15:8] == $past(rep.gesture_raw[15:8]))
    else $error("swipe bits not captured");
endmodule

// File: rtl/tsr_tune.sv
/*
  Tuning result flags of the information word.
  Assumes tune_raw holds done and error bits valid with report_stb.
*/
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_tune (
  input wire logic core_clk,
  input wire logic rst_n,
  tsr_rep_if.tune rep
);
  logic [3:0] bits_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_q <= `TSR_TUNE_RST;
    end else if (rep.report_stb) begin
      bits_q <= rep.tune_raw;
    end
  end

  assign rep.tune_bits = bits_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  tune_capture_a:
    assert property (rep.report_stb |=> rep.tune_bits == $past(rep.tune_raw))
    else $error("tuning flags not captured");
  tune_hold_a:
    assert property (!rep.report_stb |=> $stable(rep.tune_bits))
    else $error("tuning flags changed between reports");
endmodule

// File: rtl/tsr_top.sv
/*
  Read-only report words of the trackpad controller: version words,
  gesture word and information word, plus the reset acknowledge path.
  Assumes the serial port front end presents one word access per
  acc_rd or acc_wr pulse, and the sensing engine presents its results
  with a one-cycle report_stb, all on core_clk.
*/
// Behaviour
// - Gesture bits 15..12 report swipe-and-hold directions
// - Gesture bits 11..8 report plain swipe directions
// - Bits 4..0 palm, hold, taps; 7..5 zero
// - Info bit 14 shows low-power channel detect
// - Info bit 12 set when fingers exceed maximum
// - Info bit 10 shows finger movement
// - Info bits 9..8 give finger count
// - Info bit 7 set after reset until acknowledged
// - Info bit 6 shows low-power channel retune done
// - Info bit 5 shows low-power tuning failure
// - Info bit 4 shows trackpad retune done
// - Info bit 3 shows trackpad tuning failure
// - Info bits 2..0 give power mode
// - Fixed version words at addresses 0x00..0x09
// - Gesture events only when gesture enable set
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_top #(
  // Identity words below are arbitrary values
  parameter tsr_pkg::tsr_word_type PRODUCT_NUMBER = 16'h0A5A,
  parameter tsr_pkg::tsr_word_type APP_MAJOR = 16'h0001,
  parameter tsr_pkg::tsr_word_type APP_MINOR = 16'h0001,
  parameter tsr_pkg::tsr_word_type APP_PATCH_LO = 16'h1234,
  parameter tsr_pkg::tsr_word_type APP_PATCH_HI = 16'h5678,
  parameter tsr_pkg::tsr_word_type LIBRARY_NUMBER = 16'h00C3,
  parameter tsr_pkg::tsr_word_type LIB_MAJOR = 16'h0004,
  parameter tsr_pkg::tsr_word_type LIB_MINOR = 16'h000F,
  parameter tsr_pkg::tsr_word_type LIB_PATCH_LO = 16'h9ABC,
  parameter tsr_pkg::tsr_word_type LIB_PATCH_HI = 16'hDEF0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire tsr_pkg::tsr_addr_type acc_addr,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire tsr_pkg::tsr_word_type acc_wdata,
  output tsr_pkg::tsr_word_type acc_rdata,
  output logic acc_rvalid,
  input wire logic report_stb,
  input wire logic [3:0] swipe_hold_dir,
  input wire logic [3:0] swipe_dir,
  input wire logic palm_gesture,
  input wire logic press_hold,
  input wire logic triple_tap,
  input wire logic double_tap,
  input wire logic single_tap,
  input wire logic low_power_detect,
  input wire logic [2:0] touch_count,
  input wire logic [1:0] max_fingers,
  input wire logic finger_motion_flag,
  input wire logic alt_channel_retuning_done,
  input wire logic alt_channel_tuning_error,
  input wire logic trackpad_retuning_done,
  input wire logic trackpad_tuning_error,
  input wire tsr_pkg::tsr_power_mode_type power_mode,
  input wire logic reset_event,
  input wire logic gesture_event_en,
  output logic comm_event
);

  ////////////////////////////////////////////////////////////////////////
  // Report bundle and capture modules

  tsr_rep_if rep ();

  assign rep.report_stb = report_stb;

  always_comb begin
    rep.gesture_raw = `TSR_WORD_RST;
    rep.gesture_raw[`TSR_GES_SWHOLD_LO +: 4] = swipe_hold_dir;
    rep.gesture_raw[`TSR_GES_SWIPE_LO +: 4] = swipe_dir;
    rep.gesture_raw[`TSR_GES_PALM] = palm_gesture;
    rep.gesture_raw[`TSR_GES_HOLD] = press_hold;
    rep.gesture_raw[`TSR_GES_TRIPLE] = triple_tap;
    rep.gesture_raw[`TSR_GES_DOUBLE] = double_tap;
    rep.gesture_raw[`TSR_GES_SINGLE] = single_tap;
  end

  assign rep.tune_raw = {alt_channel_retuning_done,
                         alt_channel_tuning_error,
                         trackpad_retuning_done, trackpad_tuning_error};

  tsr_gesture u_gesture (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .rep (rep.ges)
  );

  tsr_tune u_tune (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .rep (rep.tune)
  );

  ////////////////////////////////////////////////////////////////////////
  // Touch state of the information word

  logic lp_det_q;
  logic too_many_q;
  logic motion_q;
  logic [1:0] count_q;
  tsr_pkg::tsr_power_mode_type mode_q;
  logic [1:0] count_d;

  // count clipped to the two-finger code
  always_comb begin
    if (touch_count > 3'({1'b0, `TSR_COUNT_MAX})) begin
      count_d = `TSR_COUNT_MAX;
    end else begin
      count_d = touch_count[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_det_q <= 1'b0;
      motion_q <= 1'b0;
      count_q <= 2'h0;
    end else if (report_stb) begin
      lp_det_q <= low_power_detect;
      motion_q <= finger_motion_flag;
      count_q <= count_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      too_many_q <= 1'b0;
    end else if (report_stb) begin
      too_many_q <= touch_count > {1'b0, max_fingers};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= tsr_pkg::tsr_mode_active;
    end else if (report_stb) begin
      mode_q <= power_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset indication

  logic show_reset_q;
  logic ack_wr;

  // acknowledge only on a written one
  assign ack_wr = acc_wr && (acc_addr == `TSR_ADDR_SYSCTL)
                  && acc_wdata[`TSR_SYSCTL_ACK];

  // set by reset, cleared by acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      show_reset_q <= 1'b1;
    end else if (reset_event) begin
      show_reset_q <= 1'b1;
    end else if (ack_wr) begin
      show_reset_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Information word assembly

  tsr_pkg::tsr_word_type info_word;

  always_comb begin
    info_word = `TSR_WORD_RST;
    info_word[`TSR_INFO_LP_DET] = lp_det_q;
    info_word[`TSR_INFO_TOO_MANY] = too_many_q;
    info_word[`TSR_INFO_MOTION] = motion_q;
    info_word[`TSR_INFO_COUNT_LO +: 2] = count_q;
    info_word[`TSR_INFO_SHOW_RST] = show_reset_q;
    info_word[`TSR_INFO_ALT_RETUNE] = rep.tune_bits[3];
    info_word[`TSR_INFO_ALT_ERR] = rep.tune_bits[2];
    info_word[`TSR_INFO_PAD_RETUNE] = rep.tune_bits[1];
    info_word[`TSR_INFO_PAD_ERR] = rep.tune_bits[0];
    info_word[`TSR_INFO_MODE_LO +: 3] = mode_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Gesture communication event

  logic comm_event_q;

  // event gated by the gesture enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_event_q <= 1'b0;
    end else begin
      comm_event_q <= rep.gesture_seen && gesture_event_en;
    end
  end

  assign comm_event = comm_event_q;

  ////////////////////////////////////////////////////////////////////////
  // Word read port

  tsr_pkg::tsr_word_type rdata_d;
  tsr_pkg::tsr_word_type rdata_q;
  logic rvalid_q;

  always_comb begin
    unique case (acc_addr)
      `TSR_ADDR_PRODUCT: rdata_d = PRODUCT_NUMBER;
      `TSR_ADDR_APP_MAJOR: rdata_d = APP_MAJOR;
      `TSR_ADDR_APP_MINOR: rdata_d = APP_MINOR;
      `TSR_ADDR_APP_PATCH_LO: rdata_d = APP_PATCH_LO;
      `TSR_ADDR_APP_PATCH_HI: rdata_d = APP_PATCH_HI;
      `TSR_ADDR_LIBRARY: rdata_d = LIBRARY_NUMBER;
      `TSR_ADDR_LIB_MAJOR: rdata_d = LIB_MAJOR;
      `TSR_ADDR_LIB_MINOR: rdata_d = LIB_MINOR;
      `TSR_ADDR_LIB_PATCH_LO: rdata_d = LIB_PATCH_LO;
      `TSR_ADDR_LIB_PATCH_HI: rdata_d = LIB_PATCH_HI;
      `TSR_ADDR_GESTURE: rdata_d = rep.gesture_word;
      `TSR_ADDR_INFO: rdata_d = info_word;
      default: rdata_d = `TSR_WORD_RST;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `TSR_WORD_RST;
    end else if (acc_rd) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= acc_rd;
    end
  end

  assign acc_rdata = rdata_q;
  assign acc_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int EVT_LAT = `TSR_EVT_LAT;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence gesture_report_s;
    report_stb && (swipe_hold_dir != 4'h0 || swipe_dir != 4'h0
                   || palm_gesture || press_hold || triple_tap
                   || double_tap || single_tap);
  endsequence

  sequence ack_write_s;
    ack_wr && !reset_event;
  endsequence

  reset_ack_clear_a:
    assert property (ack_write_s |=> !info_word[`TSR_INFO_SHOW_RST])
    else $error("reset indication not cleared by acknowledge");

  reset_flag_hold_a:
    assert property (info_word[`TSR_INFO_SHOW_RST] && !ack_wr
                     |=> info_word[`TSR_INFO_SHOW_RST])
    else $error("reset indication dropped without acknowledge");

  reset_event_set_a:
    assert property (reset_event |=> info_word[`TSR_INFO_SHOW_RST])
    else $error("reset indication not set after reset event");

  ack_zero_noop_a:
    assert property (acc_wr && acc_addr == `TSR_ADDR_SYSCTL
                     && !acc_wdata[`TSR_SYSCTL_ACK]
                     && !reset_event |=> $stable(show_reset_q))
    else $error("acknowledge zero changed reset indication");

  gesture_event_on_a:
    assert property (gesture_report_s ##1 gesture_event_en
                     |=> comm_event)
    else $error("enabled gesture raised no event");

  gesture_event_off_a:
    assert property (comm_event |-> $past(gesture_event_en)
                     && $past(report_stb, EVT_LAT))
    else $error("event without enabled gesture report");

  too_many_a:
    assert property (report_stb |=> info_word[`TSR_INFO_TOO_MANY]
                     == ($past(touch_count) > {1'b0, $past(max_fingers)}))
    else $error("finger limit flag wrong");

  count_code_a:
    assert property (report_stb && touch_count <= 3'h2
                     |=> info_word[9:8] == $past(touch_count[1:0]))
    else $error("finger count code wrong");

  count_range_a:
    assert property (info_word[9:8] != 2'h3)
    else $error("finger count code out of range");

  mode_report_a:
    assert property (report_stb |=> info_word[2:0] == $past(power_mode))
    else $error("power mode not reported");

  detect_motion_a:
    assert property (report_stb |=> info_word[`TSR_INFO_LP_DET]
                     == $past(low_power_detect)
                     && info_word[`TSR_INFO_MOTION]
                     == $past(finger_motion_flag))
    else $error("detect or movement flag wrong");

  retune_flags_a:
    assert property (report_stb ##1 !report_stb |->
                     info_word[6:3] == $past(rep.tune_raw))
    else $error("tuning flags misplaced");

  version_read_a:
    assert property (acc_rd && acc_addr == `TSR_ADDR_PRODUCT
                     |=> acc_rvalid && acc_rdata == PRODUCT_NUMBER)
    else $error("product word misread");

  info_read_a:
    assert property (acc_rd && acc_addr == `TSR_ADDR_INFO
                     |=> acc_rvalid && acc_rdata == $past(info_word))
    else $error("information word misread");

  reserved_info_a:
    assert property (info_word[15] == 1'b0 && info_word[13] == 1'b0
                     && info_word[11] == 1'b0)
    else $error("reserved information bits set");

  write_ignored_a:
    assert property (acc_wr && acc_addr == `TSR_ADDR_GESTURE
                     && !report_stb |=> $stable(rep.gesture_word))
    else $error("write changed gesture word");

endmodule

// File: tb/tsr_host_model.sv
/*
  Host side of the word access port: one read or one write per call.
  Assumes the report words share core_clk and that requests change at
  the falling edge.
*/
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module tsr_host_model (
  input wire logic core_clk,
  output tsr_pkg::tsr_addr_type acc_addr,
  output logic acc_rd,
  output logic acc_wr,
  output tsr_pkg::tsr_word_type acc_wdata,
  input wire tsr_pkg::tsr_word_type acc_rdata,
  input wire logic acc_rvalid
);
  initial begin
    acc_addr = 8'h00;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read, answer taken one cycle after the request edge
  task automatic read_word(input tsr_pkg::tsr_addr_type addr,
      output tsr_pkg::tsr_word_type data, output logic valid);
    @(negedge core_clk);
    acc_addr = addr;
    acc_rd = 1'b1;
    @(negedge core_clk);
    acc_rd = 1'b0;
    acc_addr = ~addr;
    valid = acc_rvalid;
    data = acc_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Write, released address and data show their inverse
  task automatic write_word(input tsr_pkg::tsr_addr_type addr,
      input tsr_pkg::tsr_word_type data);
    @(negedge core_clk);
    acc_addr = addr;
    acc_wdata = data;
    acc_wr = 1'b1;
    @(negedge core_clk);
    acc_wr = 1'b0;
    acc_addr = ~addr;
    acc_wdata = ~data;
  endtask

  task automatic ack_reset(input logic ack);
    write_word(`TSR_ADDR_SYSCTL, {8'h00, ack, 7'h00});
  endtask
endmodule

// File: tb/test_touch_status_report_regs.sv
/*
  Self-checking bench of the report words with a host model.
  Assumes the design and package files are compiled first.
*/
`timescale 1ns/1ps
`include "tsr_cfg.svh"
module test_touch_status_report_regs;
  // Version words, arbitrary values
  localparam logic [15:0] VER [10] = '{16'h1357, 16'h0001, 16'h0001,
    16'h2468, 16'h3579, 16'h0ACE, 16'h0004, 16'h000F, 16'h4A4A, 16'h5B5B};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  tsr_pkg::tsr_addr_type acc_addr;
  logic acc_rd, acc_wr, acc_rvalid, comm_event;
  tsr_pkg::tsr_word_type acc_wdata, acc_rdata;
  logic report_stb = 1'b0;
  logic [15:0] g = 16'h0000;
  logic lpd = 1'b0, mot = 1'b0, ard = 1'b0, aer = 1'b0;
  logic trd = 1'b0, ter = 1'b0, reset_event = 1'b0, gev_en = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic [1:0] maxf = 2'h2;
  tsr_pkg::tsr_power_mode_type pmode = tsr_pkg::tsr_mode_active;
  int fails = 0;
  int tests_run = 0;

  always #2.5 core_clk = ~core_clk;

  tsr_host_model host (.core_clk(core_clk), .acc_addr(acc_addr),
    .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  tsr_top #(.PRODUCT_NUMBER(VER[0]), .APP_MAJOR(VER[1]),
    .APP_MINOR(VER[2]), .APP_PATCH_LO(VER[3]), .APP_PATCH_HI(VER[4]),
    .LIBRARY_NUMBER(VER[5]), .LIB_MAJOR(VER[6]), .LIB_MINOR(VER[7]),
    .LIB_PATCH_LO(VER[8]), .LIB_PATCH_HI(VER[9])) dut (
    .core_clk(core_clk), .rst_n(rst_n), .acc_addr(acc_addr),
    .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .report_stb(report_stb), .swipe_hold_dir(g[15:12]),
    .swipe_dir(g[11:8]), .palm_gesture(g[4]), .press_hold(g[3]),
    .triple_tap(g[2]), .double_tap(g[1]), .single_tap(g[0]),
    .low_power_detect(lpd), .touch_count(tcnt), .max_fingers(maxf),
    .finger_motion_flag(mot), .alt_channel_retuning_done(ard),
    .alt_channel_tuning_error(aer), .trackpad_retuning_done(trd),
    .trackpad_tuning_error(ter), .power_mode(pmode),
    .reset_event(reset_event), .gesture_event_en(gev_en),
    .comm_event(comm_event));

  ////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr,
      input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.read_word(addr, d, v);
    check({name, " valid"}, {15'h0000, v}, 16'h0001);
    check(name, d, exp);
  endtask

  task automatic report(input logic [15:0] gw);
    @(negedge core_clk);
    g = gw;
    report_stb = 1'b1;
    @(negedge core_clk);
    report_stb = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_versions();
    for (int i = 0; i < 10; i++) begin
      rd_chk("version", 8'(i), VER[i]);
    end
    rd_chk("unmapped", 8'h0A, 16'h0000);
    rd_chk("info reset", `TSR_ADDR_INFO, 16'h0080);
    rd_chk("gesture reset", `TSR_ADDR_GESTURE, 16'h0000);
  endtask

  task automatic test_ack();
    host.ack_reset(1'b0);
    rd_chk("info ack0", `TSR_ADDR_INFO, 16'h0080);
    host.write_word(`TSR_ADDR_INFO, 16'hFFFF);
    rd_chk("info write", `TSR_ADDR_INFO, 16'h0080);
    host.ack_reset(1'b1);
    rd_chk("info ack1", `TSR_ADDR_INFO, 16'h0000);
    fork
      host.ack_reset(1'b1);
      begin
        @(negedge core_clk);
        reset_event = 1'b1;
        @(negedge core_clk);
        reset_event = 1'b0;
      end
    join
    rd_chk("info set wins", `TSR_ADDR_INFO, 16'h0080);
    host.ack_reset(1'b1);
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rd_chk("info rerst", `TSR_ADDR_INFO, 16'h0080);
    host.ack_reset(1'b1);
  endtask

  task automatic test_gestures();
    logic [15:0] gw;
    for (int b = 0; b < 16; b++) begin
      gw = 16'h0001 << b;
      report(gw);
      // Event pulse would stand in this cycle
      @(negedge core_clk);
      check("event off", {15'h0000, comm_event}, 16'h0000);
      rd_chk("gesture bit", `TSR_ADDR_GESTURE, gw & 16'hFF1F);
    end
    host.write_word(`TSR_ADDR_GESTURE, 16'h0000);
    rd_chk("gesture write", `TSR_ADDR_GESTURE, 16'h8000);
  endtask

  task automatic test_event(input logic en, input logic [15:0] gw,
      input logic exp);
    @(negedge core_clk);
    gev_en = en;
    report(gw);
    check("event early", {15'h0000, comm_event}, 16'h0000);
    @(negedge core_clk);
    check("event", {15'h0000, comm_event}, {15'h0000, exp});
    @(negedge core_clk);
    check("event end", {15'h0000, comm_event}, 16'h0000);
  endtask

  task automatic test_info();
    logic [15:0] e;
    logic [1:0] cnt;
    for (int i = 0; i < 5; i++) begin
      tcnt = 3'(i);
      maxf = (i % 2 == 0) ? 2'h1 : 2'h2;
      lpd = i[0];
      mot = i[1];
      ard = (i == 1);
      aer = (i == 2);
      trd = (i == 3);
      ter = (i == 4);
      pmode = tsr_pkg::tsr_power_mode_type'(3'(i));
      cnt = (i > 2) ? 2'h2 : 2'(i);
      e = {1'b0, lpd, 1'b0, (3'(i) > {1'b0, maxf}), 1'b0, mot, cnt,
        1'b0, ard, aer, trd, ter, 3'(i)};
      report(16'h0000);
      rd_chk("info", `TSR_ADDR_INFO, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    test_versions();
    test_ack();
    test_gestures();
    test_event(1'b1, 16'h0001, 1'b1);
    test_event(1'b1, 16'h0000, 1'b0);
    test_event(1'b0, 16'h0400, 1'b0);
    test_info();
    summarize();
  end

  initial begin
    #50000;
    fails++;
    summarize();
  end
endmodule
